//--- wwd_cfg.svh
`ifndef WWD_CFG_SVH
`define WWD_CFG_SVH
`define WWD_OFS_CTL0     14'h1100
`define WWD_OFS_CTL1     14'h1104
`define WWD_OFS_RESTART  14'h1108
`define WWD_OFS_STATUS   14'h110C
`define WWD_KEY_CTL0     8'hC9
`define WWD_KEY_CTL1     8'hBE
`define WWD_RESTART_CODE 32'h000000A7
`define WWD_CTL0_RESET   24'h000043
`define WWD_CTL1_RESET   24'h000000
`define WWD_KEY_HI       31
`define WWD_KEY_LO       24
`define WWD_DIV_HI       2
`define WWD_DIV_LO       0
`define WWD_PER_HI       6
`define WWD_PER_LO       4
`define WWD_WIN_A_HI     10
`define WWD_WIN_A_LO     8
`define WWD_WIN_B_HI     14
`define WWD_WIN_B_LO     12
`define WWD_MODE_BIT     16
`define WWD_CLOSED_WINDOW_SELECT_BIT   0
`endif

//--- wwd_pkg.sv
package wwd_pkg;
    typedef enum logic [0:0]
    {
        WWD_MODE_WINDOW   = 1'b0,
        WWD_MODE_INTERVAL = 1'b1
    } wwd_mode_t;
endpackage

//--- wwd_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "wwd_cfg.svh"
module wwd_top
(
    // Clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        sys_rst_in,
    // Register port
    input  wire logic [13:0] reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [31:0] reg_rdata_out,
    // Watchdog outputs
    output logic             wd_error_out,
    output logic             wd_irq_out,
    output logic             wd_running_out
);
    logic [23:0] ctl0_q;
    logic [23:0] ctl1_q;
    logic        enabled_q;
    logic [24:0] count_q;
    logic [2:0]  div_cnt_q;
    logic [31:0] rdata_q;
    logic        err_q;
    logic        irq_q;

    logic        wr_ctl0;
    logic        wr_ctl1;
    logic        wr_rst;
    logic        key0_ok;
    logic        key1_ok;
    logic        restart_ok;
    logic        tick;
    logic [24:0] total_m1;
    logic [24:0] closed_end;
    logic [2:0]  win_code;
    logic        in_closed;
    logic        timeout;
    wwd_pkg::wwd_mode_t mode;

    assign wr_ctl0    = reg_wr_in && (reg_addr_in == `WWD_OFS_CTL0);
    assign wr_ctl1    = reg_wr_in && (reg_addr_in == `WWD_OFS_CTL1);
    assign wr_rst     = reg_wr_in && (reg_addr_in == `WWD_OFS_RESTART);
    assign key0_ok    = reg_wdata_in[`WWD_KEY_HI:`WWD_KEY_LO] == `WWD_KEY_CTL0;
    assign key1_ok    = reg_wdata_in[`WWD_KEY_HI:`WWD_KEY_LO] == `WWD_KEY_CTL1;
    assign restart_ok = reg_wdata_in == `WWD_RESTART_CODE;
    assign mode       = wwd_pkg::wwd_mode_t'(ctl0_q[`WWD_MODE_BIT]);

    // First control register: one keyed write enables, then locks
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            ctl0_q    <= `WWD_CTL0_RESET;
            enabled_q <= 1'b0;
        end
        else if (wr_ctl0 && key0_ok && !enabled_q)
        begin
            ctl0_q    <= reg_wdata_in[23:0];
            enabled_q <= 1'b1;
        end
    end

    // Second control register
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
            ctl1_q <= `WWD_CTL1_RESET;
        else if (wr_ctl1 && key1_ok)
            ctl1_q <= reg_wdata_in[23:0];
    end

    // Closed-window selection
    assign win_code = ctl1_q[`WWD_CLOSED_WINDOW_SELECT_BIT] ? ctl0_q[`WWD_WIN_B_HI:`WWD_WIN_B_LO]
                                              : ctl0_q[`WWD_WIN_A_HI:`WWD_WIN_A_LO];

    // Total count minus one
    always_comb
    begin
        unique case (ctl0_q[`WWD_PER_HI:`WWD_PER_LO])
            3'h0: total_m1 = 25'h1FFFFFF;
            3'h1: total_m1 = 25'h01FFFFF;
            3'h2: total_m1 = 25'h003FFFF;
            3'h3: total_m1 = 25'h0007FFF;
            3'h4: total_m1 = 25'h0000FFF;
            3'h5: total_m1 = 25'h00003FF;
            3'h6: total_m1 = 25'h00000FF;
            3'h7: total_m1 = 25'h000003F;
        endcase
    end

    // Closed-window end as a fraction of the total, in sixteenths
    always_comb
    begin
        unique case (win_code)
            3'h0: closed_end = 25'h0;
            3'h1: closed_end = (total_m1 >> 3) + 25'h1;
            3'h2: closed_end = (total_m1 >> 3) + (total_m1 >> 4) + 25'h1;
            3'h3: closed_end = (total_m1 >> 2) + 25'h1;
            3'h4: closed_end = (total_m1 >> 1) + 25'h1;
            3'h5: closed_end = (total_m1 >> 1) + (total_m1 >> 2) + 25'h1;
            3'h6: closed_end = (total_m1 >> 1) + (total_m1 >> 2) + (total_m1 >> 4) + 25'h1;
            3'h7: closed_end = (total_m1 >> 1) + (total_m1 >> 2) + (total_m1 >> 3) + 25'h1;
        endcase
    end

    assign in_closed = count_q < closed_end;
    assign tick      = enabled_q && (div_cnt_q == ctl0_q[`WWD_DIV_HI:`WWD_DIV_LO]);
    assign timeout   = tick && (count_q == total_m1);

    // Clock divider
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in || !enabled_q || tick)
            div_cnt_q <= 3'h0;
        else
            div_cnt_q <= div_cnt_q + 3'h1;
    end

    // Watchdog counter
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in || !enabled_q)
            count_q <= 25'h0;
        else if ((wr_rst && restart_ok) || timeout)
            count_q <= 25'h0;
        else if (tick)
            count_q <= count_q + 25'h1;
    end

    // Error signal to the error monitor, one-cycle pulse
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
            err_q <= 1'b0;
        else
            err_q <= (wr_ctl0 && (!key0_ok || enabled_q))
                   || (wr_ctl1 && !key1_ok)
                   || (wr_rst && !restart_ok)
                   || (wr_rst && restart_ok && in_closed && enabled_q
                       && mode == wwd_pkg::WWD_MODE_WINDOW)
                   || (timeout && mode == wwd_pkg::WWD_MODE_WINDOW);
    end

    // Interval-mode interrupt pulse
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
            irq_q <= 1'b0;
        else
            irq_q <= timeout && mode == wwd_pkg::WWD_MODE_INTERVAL;
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
            rdata_q <= 32'h0;
        else if (reg_rd_in)
        begin
            unique case (reg_addr_in)
                `WWD_OFS_CTL0:   rdata_q <= {8'h00, ctl0_q};
                `WWD_OFS_CTL1:   rdata_q <= {8'h00, ctl1_q};
                `WWD_OFS_STATUS: rdata_q <= {31'h0, enabled_q};
                default:         rdata_q <= 32'h0;
            endcase
        end
        else
            rdata_q <= 32'h0;
    end

    assign reg_rdata_out  = rdata_q;
    assign wd_error_out   = err_q;
    assign wd_irq_out     = irq_q;
    assign wd_running_out = enabled_q;
endmodule // wwd_top
`default_nettype wire

//--- wwd_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "wwd_cfg.svh"
module wwd_top_chk
(
    // Clock, reset and register port
    input  wire logic        clk_sys_in,
    input  wire logic        sys_rst_in,
    input  wire logic [13:0] reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [31:0] reg_rdata_out,
    // Watchdog outputs
    input  wire logic        wd_error_out,
    input  wire logic        wd_irq_out,
    input  wire logic        wd_running_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    wire       w0  = reg_wr_in && reg_addr_in == `WWD_OFS_CTL0;
    wire       w1  = reg_wr_in && reg_addr_in == `WWD_OFS_CTL1;
    wire       wr  = reg_wr_in && reg_addr_in == `WWD_OFS_RESTART;
    wire [7:0] key = reg_wdata_in[31:24];
    a_ctl0_bad_key: assert property (w0 && key != `WWD_KEY_CTL0 |=> wd_error_out)
        else $error("ctl0 key fault missed");
    a_ctl0_relock: assert property (w0 && wd_running_out |=> wd_error_out)
        else $error("ctl0 rewrite not flagged");
    a_enable_run: assert property (w0 && key == `WWD_KEY_CTL0 |=> wd_running_out)
        else $error("enable failed");
    a_ctl1_bad_key: assert property (w1 && key != `WWD_KEY_CTL1 |=> wd_error_out)
        else $error("ctl1 key fault missed");
    a_ctl1_key_read: assert property (reg_rd_in && reg_addr_in == `WWD_OFS_CTL1
        |=> reg_rdata_out[31:24] == 8'h00) else $error("ctl1 key byte visible");
    a_restart_bad: assert property (wr && reg_wdata_in != `WWD_RESTART_CODE |=> wd_error_out)
        else $error("bad restart not flagged");
    a_restart_read: assert property (reg_rd_in && reg_addr_in == `WWD_OFS_RESTART
        |=> reg_rdata_out == 32'h0) else $error("restart reads nonzero");
    a_irq_pulse: assert property ($rose(wd_irq_out) |=> !wd_irq_out)
        else $error("irq longer than one cycle");
    c_enable: cover property ($rose(wd_running_out));
    c_error: cover property (wd_error_out);
    c_irq: cover property (wd_irq_out);
endmodule // wwd_top_chk
bind wwd_top wwd_top_chk u_wwd_top_chk (.clk_sys_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .wd_error_out, .wd_irq_out, .wd_running_out);
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "wwd_cfg.svh"
module testbench;
    localparam logic [13:0] CT0 = `WWD_OFS_CTL0;
    localparam logic [13:0] CT1 = `WWD_OFS_CTL1;
    localparam logic [13:0] RST = `WWD_OFS_RESTART;
    logic        clk_sys_in   = 1'b0;
    logic        sys_rst_in   = 1'b1;
    logic [13:0] reg_addr_in  = 14'h0000;
    logic [31:0] reg_wdata_in = 32'h00000000;
    logic        reg_wr_in    = 1'b0;
    logic        reg_rd_in    = 1'b0;
    logic [31:0] reg_rdata_out;
    logic        wd_error_out, wd_irq_out, wd_running_out;
    int          errors = 0;
    int          cmp_count = 0;
    int          n;
    wwd_top u_wwd_top (.clk_sys_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
        .reg_rd_in, .reg_rdata_out, .wd_error_out, .wd_irq_out, .wd_running_out);
    initial forever #12.5 clk_sys_in = ~clk_sys_in;
    task give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task do_reset;
        sys_rst_in <= 1'b1;
        repeat (8) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
    endtask
    // Write, then look at the error pulse in the following cycle
    task wr(input logic [13:0] a, input logic [31:0] d, input logic exp_err);
        @(posedge clk_sys_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_in    <= 1'b0;
        #1 chk("error pulse", {31'h0, wd_error_out}, {31'h0, exp_err});
    endtask
    task rd(input logic [13:0] a, input logic [31:0] exp);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_in   <= 1'b0;
        #1 chk("read data", reg_rdata_out, exp);
    endtask
    task wait_evt(input logic irq, input int lo, input int hi);
        for (n = 1; n <= 300; n++)
        begin
            @(posedge clk_sys_in);
            #1;
            if (irq ? wd_irq_out === 1'b1 : wd_error_out === 1'b1)
                break;
        end
        if (n > 300)
        begin
            errors++;
            give_verdict();
        end
        chk("pulse delay", {31'h0, n >= lo && n <= hi}, 32'h1);
    endtask
    initial
    begin
        do_reset();
        rd(CT0, 32'h00000043);
        rd(CT1, 32'h00000000);
        rd(RST, 32'h00000000);
        chk("running", {31'h0, wd_running_out}, 32'h0);
        $display("reset values done");
        wr(CT1, 32'hAA000001, 1'b1);
        rd(CT1, 32'h00000000);
        wr(CT1, 32'hBE800001, 1'b0);
        rd(CT1, 32'h00800001);
        wr(CT0, 32'h12000073, 1'b1);
        rd(CT0, 32'h00000043);
        $display("key tests done");
        wr(CT0, 32'hC9000470, 1'b0);
        chk("running", {31'h0, wd_running_out}, 32'h1);
        wr(CT0, 32'hC9000470, 1'b1);
        wr(RST, 32'h000000A8, 1'b1);
        wr(RST, 32'h000000A7, 1'b0);
        rd(RST, 32'h00000000);
        wr(CT1, 32'hBE000000, 1'b0);
        wr(RST, 32'h000000A7, 1'b1);
        repeat (40) @(posedge clk_sys_in);
        wr(RST, 32'h000000A7, 1'b0);
        wait_evt(1'b0, 60, 68);
        $display("window mode done");
        do_reset();
        wr(CT0, 32'hC9010071, 1'b0);
        wait_evt(1'b1, 124, 134);
        $display("interval mode done");
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
